/* inc/cpmc_pkg.sv */
package cpmc_pkg;

    // Clock and control cycle timing
    localparam int CLK_NS     = 40;
    localparam int CYCLE_NS   = 64000;
    localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYCLE_US   = CYCLE_NS / 1000;

    // Register word indexes, byte address is four times the index
    localparam int IDX_MODE       = 0;
    localparam int IDX_SUB        = 1;
    localparam int IDX_POS_KP     = 2;
    localparam int IDX_POS_TI     = 3;
    localparam int IDX_VEL_KP     = 4;
    localparam int IDX_VEL_TI     = 5;
    localparam int IDX_IQ_KP      = 6;
    localparam int IDX_IQ_TI      = 7;
    localparam int IDX_ID_KP      = 8;
    localparam int IDX_ID_TI      = 9;
    localparam int IDX_FF_VEL     = 10;
    localparam int IDX_FF_ACC     = 11;
    localparam int IDX_FF_VOLT    = 12;
    localparam int IDX_ACC_SCALE  = 13;
    localparam int IDX_MAX_SPEED  = 14;
    localparam int IDX_MAX_CUR    = 15;
    localparam int IDX_MAX_PWM    = 16;
    localparam int IDX_RATED_VOLT = 17;
    localparam int IDX_FB_MASK    = 18;
    localparam int NREG           = 19;
    localparam int IDX_STATUS     = 19;

    // Drive submode bits
    localparam int SUB_CLOSED   = 0;
    localparam int SUB_VEL_POS  = 1;
    localparam int SUB_ALIGN    = 4;
    localparam int SUB_REAL_TRQ = 5;

    // Feedback mask bits, one mask entry per sensor
    localparam int MB_POS  = 0;
    localparam int MB_VEL  = 1;
    localparam int MB_COMM = 2;
    localparam int MB_W    = 3;

    // Operating mode codes
    localparam logic [7:0] MODE_PP     = 8'h01;
    localparam logic [7:0] MODE_VEL    = 8'h02;
    localparam logic [7:0] MODE_PV     = 8'h03;
    localparam logic [7:0] MODE_TRQ    = 8'h04;
    localparam logic [7:0] MODE_HOM    = 8'h06;
    localparam logic [7:0] MODE_IP     = 8'h07;
    localparam logic [7:0] MODE_CSP    = 8'h08;
    localparam logic [7:0] MODE_CSV    = 8'h09;
    localparam logic [7:0] MODE_CST    = 8'h0A;
    localparam logic [7:0] MODE_CLKDIR = 8'hFF;

    // Scaling and reset values
    localparam int          PERMILLE_FULL  = 1000;
    localparam int          GAIN_SHIFT     = 8;
    localparam logic [31:0] RST_FF_VOLT    = 32'h000003E8;
    localparam logic [31:0] RST_LIMIT      = 32'h00007FFF;

    typedef logic signed [47:0] cpmc_wide_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_POS, ST_VEL, ST_CUR_Q, ST_CUR_D
    } cpmc_state_e;

endpackage

/* src/cpmc_core.sv */
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Current loop runs in every mode
// - Velocity loop off in real torque modes
// - Position loop in position modes, optional velocity
// - Each loop has proportional and integral terms
// - Outputs chain inward, each clamped to limit; velocity feed forward is added after the clamp
// - Separate torque and field current gains
// - Proportional output linear in gain
// - Smaller integrator time grows integral faster
// - Zero integrator time clears integral term
// - Scaled ramp velocity added before velocity loop
// - Velocity feed forward only with position loop
// - Scaled acceleration added before current loop
// - Acceleration feed forward off in torque modes
// - Voltage feed forward, default full scale
// - Voltage feed forward off when factor zero
// - Per sensor mask: position, velocity, commutation
// - First mask entry is sensorless observer
// - Scan from second sensor, first match wins
// - Commutate from sensor that has alignment
// - No aligned commutation sensor requests auto-align
// - Submode bit zero picks open or closed
module cpmc_core #(
    parameter int NSENS     = 4,
    parameter int DW        = 16,
    parameter int AW        = 8,
    parameter int CTRL_CLKS = cpmc_pkg::CYCLE_CLKS
) (
    // Clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [AW-1:0]       paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Ramp generator
    input  wire logic signed [DW-1:0] ramp_pos,
    input  wire logic signed [DW-1:0] ramp_vel,
    input  wire logic signed [DW-1:0] ramp_acc,
    input  wire logic signed [DW-1:0] ramp_trq,
    // Feedback sensors, sensor 0 is the observer
    input  wire logic [NSENS*DW-1:0] fb_pos,
    input  wire logic [NSENS*DW-1:0] fb_vel,
    input  wire logic [NSENS-1:0]    fb_aligned,
    input  wire logic signed [DW-1:0] torque_current_component,
    input  wire logic signed [DW-1:0] field_current_component,
    // Power stage
    output logic signed [DW-1:0]     pwm_q,
    output logic signed [DW-1:0]     pwm_d,
    output logic        [DW-1:0]     comm_angle,
    output logic                     align_req
);

    typedef struct packed {
        logic [cpmc_pkg::NREG-1:0][31:0] regs;
        cpmc_pkg::cpmc_state_e           st;
        logic [15:0]                     tick_cnt;
        logic [3:0][31:0]                acc;
        logic signed [DW-1:0]            vel_sp;
        logic signed [DW-1:0]            cur_sp;
        logic signed [DW-1:0]            pwm_q;
        logic signed [DW-1:0]            pwm_d;
        logic [DW-1:0]                   comm_angle;
        logic [3:0]                      pos_sel;
        logic [3:0]                      vel_sel;
        logic [3:0]                      comm_sel;
        logic                            align_req;
        logic                            pos_en;
        logic                            vel_en;
        logic                            vff_en;
        logic                            aff_en;
        logic                            vof_en;
        logic                            pready;
        logic                            pslverr;
        logic [31:0]                     prdata;
    } cpmc_state_s;

    cpmc_state_s s_reg;
    cpmc_state_s s_next;

    // Saturate to a symmetric limit
    function automatic cpmc_pkg::cpmc_wide_t sat(
        input cpmc_pkg::cpmc_wide_t x,
        input logic [31:0]          lim
    );
        cpmc_pkg::cpmc_wide_t l;
        l = cpmc_pkg::cpmc_wide_t'({1'b0, lim[14:0]});
        if (x > l) begin
            sat = l;
        end else if (x < -l) begin
            sat = -l;
        end else begin
            sat = x;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        cpmc_state_s          n;
        logic [31:0]          sub;
        logic [7:0]           mode;
        logic                 pos_mode;
        logic                 vel_mode;
        logic                 trq_mode;
        logic                 acc_ph;
        logic [AW-3:0]        widx;
        logic [31:0]          rd;
        logic [3:0]           psel_i;
        logic [3:0]           vsel_i;
        logic [3:0]           csel_i;
        logic                 cfound;
        logic signed [DW-1:0] sp;
        logic signed [DW-1:0] fb;
        logic [31:0]          kp;
        logic [31:0]          ti;
        logic [31:0]          lim;
        logic [1:0]           k;
        cpmc_pkg::cpmc_wide_t err;
        cpmc_pkg::cpmc_wide_t prop;
        cpmc_pkg::cpmc_wide_t inc;
        cpmc_pkg::cpmc_wide_t accn;
        cpmc_pkg::cpmc_wide_t outw;
        cpmc_pkg::cpmc_wide_t vff;
        cpmc_pkg::cpmc_wide_t aff;
        cpmc_pkg::cpmc_wide_t vof;
        n        = s_reg;
        sub      = s_reg.regs[cpmc_pkg::IDX_SUB];
        mode     = s_reg.regs[cpmc_pkg::IDX_MODE][7:0];
        rd       = 32'h00000000;
        sp       = '0;
        fb       = '0;
        kp       = 32'h00000000;
        ti       = 32'h00000000;
        lim      = 32'h00000000;
        k        = 2'h0;

        // Mode decode, torque modes have no position loop option
        pos_mode = (mode == cpmc_pkg::MODE_PP) || (mode == cpmc_pkg::MODE_HOM)
                || (mode == cpmc_pkg::MODE_IP) || (mode == cpmc_pkg::MODE_CSP)
                || (mode == cpmc_pkg::MODE_CLKDIR);
        vel_mode = (mode == cpmc_pkg::MODE_VEL) || (mode == cpmc_pkg::MODE_PV)
                || (mode == cpmc_pkg::MODE_CSV);
        trq_mode = (mode == cpmc_pkg::MODE_TRQ) || (mode == cpmc_pkg::MODE_CST);
        // Open loop drops outer loops, current loop stays
        n.pos_en = sub[cpmc_pkg::SUB_CLOSED]
                && (pos_mode || (vel_mode && sub[cpmc_pkg::SUB_VEL_POS]));
        n.vel_en = sub[cpmc_pkg::SUB_CLOSED]
                && !(trq_mode && sub[cpmc_pkg::SUB_REAL_TRQ]);
        n.vff_en = sub[cpmc_pkg::SUB_CLOSED] && (pos_mode
                || (((mode == cpmc_pkg::MODE_VEL) || (mode == cpmc_pkg::MODE_PV))
                && sub[cpmc_pkg::SUB_VEL_POS]));
        n.aff_en = !trq_mode;
        n.vof_en = s_reg.regs[cpmc_pkg::IDX_FF_VOLT] != 32'h00000000;

        // Sensor scan from the top sensor down to sensor 1, lowest index wins
        psel_i = 4'h0;
        vsel_i = 4'h0;
        csel_i = 4'h0;
        cfound = 1'b0;
        for (int i = NSENS - 1; i >= 1; i--) begin
            if (s_reg.regs[cpmc_pkg::IDX_FB_MASK][i*cpmc_pkg::MB_W
                    + cpmc_pkg::MB_POS]) begin
                psel_i = 4'(i);
            end
            if (s_reg.regs[cpmc_pkg::IDX_FB_MASK][i*cpmc_pkg::MB_W
                    + cpmc_pkg::MB_VEL]) begin
                vsel_i = 4'(i);
            end
            // Only an aligned sensor may commutate
            if (s_reg.regs[cpmc_pkg::IDX_FB_MASK][i*cpmc_pkg::MB_W
                    + cpmc_pkg::MB_COMM] && fb_aligned[i]) begin
                csel_i = 4'(i);
                cfound = 1'b1;
            end
        end

        // Operand select for the shared PI datapath
        case (s_reg.st)
            cpmc_pkg::ST_POS: begin
                sp  = ramp_pos;
                fb  = fb_pos[s_reg.pos_sel*DW +: DW];
                kp  = s_reg.regs[cpmc_pkg::IDX_POS_KP];
                ti  = s_reg.regs[cpmc_pkg::IDX_POS_TI];
                lim = s_reg.regs[cpmc_pkg::IDX_MAX_SPEED];
                k   = 2'h0;
            end
            cpmc_pkg::ST_VEL: begin
                sp  = s_reg.vel_sp;
                fb  = fb_vel[s_reg.vel_sel*DW +: DW];
                kp  = s_reg.regs[cpmc_pkg::IDX_VEL_KP];
                ti  = s_reg.regs[cpmc_pkg::IDX_VEL_TI];
                lim = s_reg.regs[cpmc_pkg::IDX_MAX_CUR];
                k   = 2'h1;
            end
            cpmc_pkg::ST_CUR_Q: begin
                sp  = s_reg.cur_sp;
                fb  = torque_current_component;
                kp  = s_reg.regs[cpmc_pkg::IDX_IQ_KP];
                ti  = s_reg.regs[cpmc_pkg::IDX_IQ_TI];
                lim = s_reg.regs[cpmc_pkg::IDX_MAX_PWM];
                k   = 2'h2;
            end
            cpmc_pkg::ST_CUR_D: begin
                sp  = '0; // Field current target is zero
                fb  = field_current_component;
                kp  = s_reg.regs[cpmc_pkg::IDX_ID_KP];
                ti  = s_reg.regs[cpmc_pkg::IDX_ID_TI];
                lim = s_reg.regs[cpmc_pkg::IDX_MAX_PWM];
                k   = 2'h3;
            end
            default: begin
                sp = '0;
            end
        endcase

        // PI term; integral clamped to the limit against windup
        err  = cpmc_pkg::cpmc_wide_t'(sp) - cpmc_pkg::cpmc_wide_t'(fb);
        prop = (err * cpmc_pkg::cpmc_wide_t'({1'b0, kp[15:0]}))
               >>> cpmc_pkg::GAIN_SHIFT;
        inc  = (prop * 48'(cpmc_pkg::CYCLE_US))
               / cpmc_pkg::cpmc_wide_t'({1'b0, (ti[15:0] == 16'h0000)
               ? 16'h0001 : ti[15:0]});
        accn = (ti[15:0] == 16'h0000) ? '0
               : sat(cpmc_pkg::cpmc_wide_t'($signed(s_reg.acc[k])) + inc, lim);
        outw = prop + accn;

        // Feed forward terms, all in permille
        vff = (cpmc_pkg::cpmc_wide_t'(ramp_vel)
              * cpmc_pkg::cpmc_wide_t'({1'b0, s_reg.regs[cpmc_pkg::IDX_FF_VEL][15:0]}))
              / 48'(cpmc_pkg::PERMILLE_FULL);
        aff = (((cpmc_pkg::cpmc_wide_t'(ramp_acc) * cpmc_pkg::cpmc_wide_t'({1'b0,
              s_reg.regs[cpmc_pkg::IDX_ACC_SCALE][15:0]})) >>> cpmc_pkg::GAIN_SHIFT)
              * cpmc_pkg::cpmc_wide_t'({1'b0, s_reg.regs[cpmc_pkg::IDX_FF_ACC][15:0]}))
              / 48'(cpmc_pkg::PERMILLE_FULL);
        vof = (cpmc_pkg::cpmc_wide_t'({1'b0, s_reg.regs[cpmc_pkg::IDX_RATED_VOLT][15:0]})
              * cpmc_pkg::cpmc_wide_t'({1'b0, s_reg.regs[cpmc_pkg::IDX_FF_VOLT][15:0]}))
              / 48'(cpmc_pkg::PERMILLE_FULL);

        // Control cycle sequencer, outer to inner in one cycle
        n.tick_cnt = (s_reg.tick_cnt == 16'(CTRL_CLKS - 1)) ? 16'h0000
                   : s_reg.tick_cnt + 16'h0001;
        case (s_reg.st)
            cpmc_pkg::ST_IDLE: begin
                if (s_reg.tick_cnt == 16'(CTRL_CLKS - 1)) begin
                    n.st = cpmc_pkg::ST_POS;
                end
            end
            cpmc_pkg::ST_POS: begin
                n.st = cpmc_pkg::ST_VEL;
                if (s_reg.pos_en) begin
                    n.acc[0] = accn[31:0];
                    n.vel_sp = DW'(sat(outw, lim)
                             + (s_reg.vff_en ? vff : '0));
                end else begin
                    n.acc[0] = 32'h00000000;
                    n.vel_sp = ramp_vel;
                end
            end
            cpmc_pkg::ST_VEL: begin
                n.st = cpmc_pkg::ST_CUR_Q;
                if (s_reg.vel_en) begin
                    n.acc[1] = accn[31:0];
                    n.cur_sp = DW'(sat(sat(outw, lim)
                             + (s_reg.aff_en ? aff : '0), lim));
                end else begin
                    n.acc[1] = 32'h00000000;
                    // Open loop feeds full current, torque mode its target
                    n.cur_sp = sub[cpmc_pkg::SUB_CLOSED] ? ramp_trq
                             : DW'(s_reg.regs[cpmc_pkg::IDX_MAX_CUR][14:0]);
                end
            end
            cpmc_pkg::ST_CUR_Q: begin
                n.st     = cpmc_pkg::ST_CUR_D;
                n.acc[2] = accn[31:0];
                n.pwm_q  = DW'(sat(outw + (s_reg.vof_en ? vof : '0), lim));
            end
            cpmc_pkg::ST_CUR_D: begin
                n.st       = cpmc_pkg::ST_IDLE;
                n.acc[3]   = accn[31:0];
                n.pwm_d    = DW'(sat(outw, lim));
                // Sensorless observer is the fallback
                n.pos_sel  = psel_i;
                n.vel_sel  = vsel_i;
                n.comm_sel = csel_i;
                n.comm_angle = fb_pos[csel_i*DW +: DW];
                n.align_req  = !cfound;
            end
            default: begin
                n.st = cpmc_pkg::ST_IDLE;
            end
        endcase

        // APB: one wait state, then ready with registered data
        acc_ph = psel && penable;
        widx   = paddr[AW-1:2];
        for (int r = 0; r < cpmc_pkg::NREG; r++) begin
            if (int'(widx) == r) begin
                rd = s_reg.regs[r];
            end
        end
        if (int'(widx) == cpmc_pkg::IDX_STATUS) begin
            rd = {12'h000, s_reg.align_req, s_reg.vof_en, s_reg.aff_en,
                  s_reg.vff_en, s_reg.vel_en, s_reg.pos_en, 2'h0,
                  s_reg.comm_sel, s_reg.vel_sel, s_reg.pos_sel};
        end
        n.pready = acc_ph && !s_reg.pready;
        if (acc_ph && !s_reg.pready) begin
            n.prdata  = pwrite ? 32'h00000000 : rd;
            n.pslverr = int'(widx) > cpmc_pkg::IDX_STATUS;
        end
        // Write lands at the edge where ready is seen
        if (acc_ph && s_reg.pready && pwrite) begin
            for (int r = 0; r < cpmc_pkg::NREG; r++) begin
                if (int'(widx) == r) begin
                    for (int b = 0; b < 4; b++) begin
                        if (pstrb[b]) begin
                            n.regs[r][b*8 +: 8] = pwdata[b*8 +: 8];
                        end
                    end
                end
            end
        end
        s_next = n;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, frozen while enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.regs[cpmc_pkg::IDX_FF_VOLT]   <= cpmc_pkg::RST_FF_VOLT;
            s_reg.regs[cpmc_pkg::IDX_MAX_SPEED] <= cpmc_pkg::RST_LIMIT;
            s_reg.regs[cpmc_pkg::IDX_MAX_CUR]   <= cpmc_pkg::RST_LIMIT;
            s_reg.regs[cpmc_pkg::IDX_MAX_PWM]   <= cpmc_pkg::RST_LIMIT;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign prdata     = s_reg.prdata;
    assign pready     = s_reg.pready;
    assign pslverr    = s_reg.pslverr;
    assign pwm_q      = s_reg.pwm_q;
    assign pwm_d      = s_reg.pwm_d;
    assign comm_angle = s_reg.comm_angle;
    assign align_req  = s_reg.align_req;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_loop_order: assert property (
        ce [*4] ##0 (s_reg.st == cpmc_pkg::ST_POS) |=>
        (s_reg.st == cpmc_pkg::ST_VEL) ##1 (s_reg.st == cpmc_pkg::ST_CUR_Q)
        ##1 (s_reg.st == cpmc_pkg::ST_CUR_D))
        else $error("loop order broken");
    a_real_trq_vel: assert property (
        ($past(ce) && $past(s_reg.regs[cpmc_pkg::IDX_MODE][7:0])
         == cpmc_pkg::MODE_TRQ && $past(s_reg.regs[cpmc_pkg::IDX_SUB][5]))
        |-> !s_reg.vel_en)
        else $error("velocity loop on in real torque");
    a_pos_loop_en: assert property (
        ($past(ce) && $past(s_reg.regs[cpmc_pkg::IDX_SUB][1:0]) == 2'h3
         && $past(s_reg.regs[cpmc_pkg::IDX_MODE][7:0]) == cpmc_pkg::MODE_CSV)
        |-> s_reg.pos_en)
        else $error("position loop not enabled");
    a_ti_zero_p: assert property (
        (ce && s_reg.st == cpmc_pkg::ST_POS
         && s_reg.regs[cpmc_pkg::IDX_POS_TI][15:0] == 16'h0000)
        |=> s_reg.acc[0] == 32'h00000000)
        else $error("integral not cleared");
    a_pwm_clamped: assert property (
        ($signed(s_reg.pwm_q) <= $signed({1'b0, s_reg.regs[cpmc_pkg::IDX_MAX_PWM][14:0]}))
        && ($signed(s_reg.pwm_q) >= -$signed({1'b0, s_reg.regs[cpmc_pkg::IDX_MAX_PWM][14:0]})))
        else $error("pwm beyond limit");
    a_no_pos_vff: assert property (
        (ce && s_reg.st == cpmc_pkg::ST_POS && !s_reg.pos_en)
        |=> s_reg.vel_sp == $past(ramp_vel))
        else $error("velocity feed forward without position loop");
    a_align_fallback: assert property (
        (ce && s_reg.st == cpmc_pkg::ST_CUR_D && fb_aligned == '0)
        |=> s_reg.align_req)
        else $error("auto-align not requested");
    a_vof_off: assert property (
        ($past(ce) && $past(s_reg.regs[cpmc_pkg::IDX_FF_VOLT]) == 32'h0)
        |-> !s_reg.vof_en)
        else $error("voltage feed forward not off");
    a_apb_wait: assert property (
        (psel && penable && !pready && ce) |=> pready ##1 !pready)
        else $error("apb ready not one cycle");

    c_cycle_done: cover property (s_reg.st == cpmc_pkg::ST_CUR_D);
    c_align_req:  cover property ($rose(s_reg.align_req));
    c_comm_sens:  cover property (s_reg.comm_sel != 4'h0);
    c_apb_write:  cover property (psel && penable && pready && pwrite);

endmodule

/* tb/cpmc_sensor_model.sv */
`timescale 1ns/1ps
module cpmc_sensor_model #(
    parameter int NSENS = 4,
    parameter int DW    = 16
) (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Scenario control
    input  wire logic            lose_align,
    // Sensors and measured currents
    output logic [NSENS*DW-1:0]  fb_pos,
    output logic [NSENS*DW-1:0]  fb_vel,
    output logic [NSENS-1:0]     fb_aligned,
    output logic signed [DW-1:0] iq_meas,
    output logic signed [DW-1:0] id_meas
);
    logic [DW-1:0] angle_reg;
    ////////////////////////////////////////////////////////////////////
    // Rotor turns every clock, so no position reading ever freezes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_reg <= '0;
        end else begin
            angle_reg <= angle_reg + 1'b1;
        end
    end
    // Sensor 0 is the observer and is always present
    always_comb begin
        for (int i = 0; i < NSENS; i++) begin
            fb_pos[i*DW +: DW] = angle_reg + DW'(i * 256);
            fb_vel[i*DW +: DW] = DW'(i + 1);
        end
    end
    // Only sensor two is aligned, unless the bench drops it
    assign fb_aligned = lose_align ? '0 : NSENS'(4);
    assign iq_meas    = signed'({{(DW-4){1'b0}}, angle_reg[3:0]});
    assign id_meas    = -iq_meas;
endmodule

/* tb/cascaded_pi_motor_control_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin \
    n_checks++; \
    if ((a) !== (e)) begin \
        fail_count++; \
        $display("wrong value at %0t: got %h expected %h", $time, a, e); \
    end \
end
module cascaded_pi_motor_control_tb;
    typedef struct packed {
        logic        we;
        logic [7:0]  idx;
        logic [31:0] d;
        logic        err;
    } cpmc_row_s;
    localparam int NROW = 24;
    // Write rows carry data, read rows the expected word
    cpmc_row_s rows [NROW] = '{
        '{1'h0, 8'h0C, 32'h000003E8, 1'h0}, '{1'h0, 8'h10, 32'h00007FFF, 1'h0},
        '{1'h0, 8'h14, 32'h00000000, 1'h1}, '{1'h1, 8'h14, 32'h00000000, 1'h1},
        '{1'h1, 8'h12, 32'h000001F0, 1'h0}, '{1'h1, 8'h0A, 32'h000001F4, 1'h0},
        '{1'h1, 8'h0B, 32'h000001F4, 1'h0}, '{1'h1, 8'h00, 32'h00000001, 1'h0},
        '{1'h1, 8'h01, 32'h00000001, 1'h0}, '{1'h0, 8'h13, 32'h0007C212, 1'h0},
        '{1'h1, 8'h00, 32'h00000004, 1'h0}, '{1'h1, 8'h01, 32'h00000021, 1'h0},
        '{1'h0, 8'h13, 32'h00040212, 1'h0}, '{1'h1, 8'h00, 32'h00000003, 1'h0},
        '{1'h1, 8'h01, 32'h00000003, 1'h0}, '{1'h0, 8'h13, 32'h0007C212, 1'h0},
        '{1'h1, 8'h00, 32'h00000009, 1'h0}, '{1'h0, 8'h13, 32'h0006C212, 1'h0},
        '{1'h1, 8'h00, 32'h00000002, 1'h0}, '{1'h1, 8'h01, 32'h00000001, 1'h0},
        '{1'h0, 8'h13, 32'h00068212, 1'h0}, '{1'h1, 8'h0C, 32'h00000000, 1'h0},
        '{1'h1, 8'h13, 32'hFFFFFFFF, 1'h0}, '{1'h0, 8'h13, 32'h00028212, 1'h0}
    };
    logic               pclk = 1'b0, presetn = 1'b0, lose_align = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h00000000, prdata, rd;
    logic               pready, pslverr, err, align_req;
    logic signed [15:0] ramp = 16'h0100, iq_meas, id_meas;
    logic [63:0]        fb_pos, fb_vel;
    logic [3:0]         fb_aligned;
    logic signed [15:0] pwm_q, pwm_d;
    logic [15:0]        comm_angle, snap, ang;
    int                 fail_count = 0, n_checks = 0, n_wait = 0;
    ////////////////////////////////////////////////////////////////////
    always #(cpmc_pkg::CLK_NS / 2) pclk = ~pclk;
    // Short control cycle keeps the run brief
    cpmc_core #(.CTRL_CLKS(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ramp_pos(ramp), .ramp_vel(ramp),
        .ramp_acc(ramp), .ramp_trq(ramp), .fb_pos(fb_pos),
        .fb_vel(fb_vel), .fb_aligned(fb_aligned),
        .torque_current_component(iq_meas),
        .field_current_component(id_meas), .pwm_q(pwm_q), .pwm_d(pwm_d),
        .comm_angle(comm_angle), .align_req(align_req));
    cpmc_sensor_model i_model (
        .pclk(pclk), .presetn(presetn), .lose_align(lose_align),
        .fb_pos(fb_pos), .fb_vel(fb_vel), .fb_aligned(fb_aligned),
        .iq_meas(iq_meas), .id_meas(id_meas));
    ////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic we, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= we;
        paddr  <= {idx[5:0], 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready sampled at each edge; data taken at the ready edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            `CHK(pready, 1'b1)
            final_report();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < NROW; i++) begin
            apb(rows[i].we, rows[i].idx, rows[i].d);
            `CHK(err, rows[i].err)
            if (!rows[i].we && !rows[i].err) begin
                `CHK(rd, rows[i].d)
            end
            repeat (12) @(posedge pclk);
        end
        // Angle from sensor two, as it stood at the capture edge
        ang = comm_angle;
        while (comm_angle === ang && n_wait < 20) begin
            snap = fb_pos[47:32];
            @(posedge pclk);
            n_wait++;
        end
        if (n_wait >= 20) begin
            fail_count++;
            final_report();
        end
        `CHK(comm_angle, snap)
        // Aligned commutation sensor disappears
        lose_align <= 1'b1;
        repeat (12) @(posedge pclk);
        apb(1'b0, 8'h13, 32'h00000000);
        `CHK(rd, 32'h000A8012)
        `CHK(align_req, 1'b1)
        // Voltage feed forward on the torque axis only, first under the clamp, then unclamped
        apb(1'b1, 8'h10, 32'h00000040);
        apb(1'b1, 8'h11, 32'h00000100);
        apb(1'b1, 8'h0C, 32'h000001F4);
        repeat (12) @(posedge pclk);
        `CHK(pwm_q, 16'h0040)
        `CHK(pwm_d, 16'h0000)
        apb(1'b1, 8'h10, 32'h00007FFF);
        repeat (12) @(posedge pclk);
        `CHK(pwm_q, 16'h0080)
        // Second reset in mid-run restores defaults
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK(align_req, 1'b0)
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h0C, 32'h00000000);
        `CHK(rd, 32'h000003E8)
        apb(1'b0, 8'h13, 32'h00000000);
        `CHK(rd[11:0], 12'h000)
        final_report();
    end
endmodule
